/* File: bench/host_spi_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_spi_model (
    // clock
    input wire logic sys_clk,
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so_out,
    input wire logic so_oe_n
);
    logic wd_bit = 1'b0;
    // idle link: clock low, select high, data at pulldown level
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // one word, watchdog bit flipped every word so the timer keeps restarting
    task automatic xfer(input logic [14:0] body, output logic [15:0] resp);
        wd_bit = ~wd_bit;
        @(negedge sys_clk);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (4) @(negedge sys_clk);
            resp[i] = so_oe_n ? ~so_out : so_out; // taken before the rise; an undriven line reads wrong
            sclk = 1'b1;
            si = (i == 15) ? wd_bit : body[i];
            repeat (4) @(negedge sys_clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        cs_n = 1'b1;
        si = 1'b0; // released line falls to its pulldown
        repeat (6) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* File: bench/switch_fault_supervisor_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module switch_fault_supervisor_bench;
    import sfs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wake = 1'b0;
    strap_t strap = STRAP_CH0_CH2;
    logic [3:0] din = 4'h0;
    logic vdd_ok = 1'b1;
    logic ov = 1'b0;
    logic [3:0] hot = 4'h0;
    logic [3:0] hi_hit = 4'h0;
    logic rstn = 1'b0;
    logic uv = 1'b0;
    logic [2:0] oc_lo;
    logic oc_hi;
    logic sclk, cs_n, si, so_out, so_oe_n, flag_n, wd_exp;
    logic [3:0] sw;
    logic [15:0] r;
    mode_t mode;
    int fails = 0;
    int num_checks = 0;

    // ****************************************
    // design and host
    // ****************************************
    switch_fault_supervisor #(.WD_STEP(200), .OC_STEP(20)) i_switch_fault_supervisor (
        .sys_clk(sys_clk), .rst(rst), .wake(wake), .device_reset_n(rstn),
        .fail_safe_strap_resistor(strap), .direct_drive_inputs(din),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_si(si), .spi_so_out(so_out), .spi_so_oe_n(so_oe_n),
        .vdd_ok(vdd_ok), .overvoltage(ov), .undervoltage(uv), .overtemp_hot(hot),
        .open_load(4'h0), .oc_low_hit(4'h0), .oc_high_hit(hi_hit),
        .overcurrent_low_level_field(oc_lo), .overcurrent_high_level_field(oc_hi),
        .switch_out(sw), .fault_flag_n(flag_n), .watchdog_expired_status(wd_exp), .mode(mode)
    );
    host_spi_model i_host_spi_model (
        .sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n)
    );

    // ****************************************
    // helpers
    // ****************************************
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic w(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [2:0] addr, input logic [11:0] data);
        i_host_spi_model.xfer({addr, data}, r);
        w(6);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_wake_and_drive();
        check("sleep outputs", sw, 4'h0);
        check("sleep mode", mode, MODE_SLEEP);
        wake = 1'b1;
        w(6);
        check("awake mode", mode, MODE_NORMAL);
        cmd(3'h0, 12'h00f);
        check("commanded on", sw, 4'hf);
        cmd(3'h1, 12'h00b);
        check("oc levels", {oc_hi, oc_lo}, 4'hb);
    endtask
    task automatic t_overvoltage();
        ov = 1'b1;
        w(6);
        check("ov off", sw, 4'h0);
        check("ov flag pin", flag_n, 1'b0);
        ov = 1'b0;
        w(6);
        check("ov recovers", sw, 4'hf);
        check("ov flag pin back", flag_n, 1'b1);
        uv = 1'b1;
        w(6);
        check("uv flag pin", flag_n, 1'b0);
        uv = 1'b0;
        w(6);
        check("uv flag pin back", flag_n, 1'b1);
        cmd(3'h4, 12'h000);
        check("ov bit", r[1], 1'b1);
        cmd(3'h4, 12'h000);
        check("ov bit cleared", r[1], 1'b0);
    endtask
    task automatic t_overcurrent();
        hi_hit = 4'h1;
        w(6);
        check("oc trip", sw, 4'he);
        hi_hit = 4'h0;
        w(6);
        check("oc stays off", sw, 4'he);
        check("oc flag held", flag_n, 1'b0);
        cmd(3'h0, 12'h00e);
        check("oc report", r[7:4], 4'h1);
        cmd(3'h0, 12'h00f);
        check("oc reenabled", sw, 4'hf);
        check("oc flag released", flag_n, 1'b1);
    endtask
    task automatic t_overtemp();
        hot = 4'h1;
        w(6);
        check("ot off", sw, 4'he);
        hot = 4'h0;
        w(6);
        check("ot latched", sw, 4'he);
        cmd(3'h0, 12'h00e);
        check("ot report", r[11:4], 8'h11);
        cmd(3'h0, 12'h00f);
        check("ot reenabled", sw, 4'hf);
    endtask
    task automatic t_failsafe();
        w(300);
        check("fs mode", mode, MODE_FAILSAFE);
        check("fs pattern", sw, 4'h5);
        check("fs status", wd_exp, 1'b1);
        check("fs defaults", {oc_hi, oc_lo}, 4'h0);
        strap = STRAP_GROUND;
        w(6);
        check("fs exit", mode, MODE_NORMAL);
        w(300);
        check("wd disabled", mode, MODE_NORMAL);
        vdd_ok = 1'b0;
        din = 4'h3;
        w(6);
        check("vdd loss direct", sw, 4'h3);
    endtask
    task automatic t_reset_pin_exit();
        strap = STRAP_CH0;
        vdd_ok = 1'b1;
        rstn = 1'b1;
        w(300);
        check("reset pin arms", mode, MODE_FAILSAFE);
        check("fs ch0 only", sw, 4'h1);
        wake = 1'b0;
        rstn = 1'b0;
        w(6);
        check("both fell exit", mode, MODE_SLEEP);
        check("sleep off", sw, 4'h0);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        w(8);
        rst = 1'b0;
        w(6);
        t_wake_and_drive();
        t_overvoltage();
        t_overcurrent();
        t_overtemp();
        t_failsafe();
        t_reset_pin_exit();
        close_out();
    end
    initial begin
        #600000;
        fails++;
        close_out();
    end
endmodule
`default_nettype wire

/* File: core/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // asynchronous pins and their synchronised copy
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;

    // two flops; stage1 is read by level only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            level <= '0;
        end else begin
            stage1 <= pin;
            level <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: core/spi_word_slave.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfs_consts.svh"
module spi_word_slave (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // synchronised link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    // serial output as two signals
    output logic so_out,
    output logic so_oe_n,
    // word side
    input wire logic [`SPI_WORD_BITS-1:0] tx_word,
    output logic [`SPI_WORD_BITS-1:0] rx_word,
    output logic start,
    output logic done
);
    logic sclk_prev;
    logic cs_prev;
    logic [4:0] bit_cnt;
    logic [`SPI_WORD_BITS-1:0] shift_in;
    logic [`SPI_WORD_BITS-1:0] shift_out;

    // edge detection on the sampled link clock (8 sys cycles per period)
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk;
            cs_prev <= cs_n;
        end
    end

    assign start = cs_prev && !cs_n;
    // only a frame of exactly sixteen bits counts as valid
    assign done = !cs_prev && cs_n && (bit_cnt == 5'(`SPI_WORD_BITS));
    assign so_oe_n = cs_n;
    assign so_out = shift_out[`SPI_WORD_BITS-1];

    // receive on falling clock, msb first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_in <= '0;
            bit_cnt <= '0;
        end else if (start) begin
            bit_cnt <= '0;
        end else if (!cs_n && sclk_prev && !sclk) begin
            shift_in <= {shift_in[`SPI_WORD_BITS-2:0], si};
            if (bit_cnt != 5'h1f) begin
                bit_cnt <= bit_cnt + 5'h1;
            end
        end
    end

    // transmit: load at frame start, advance on rising clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_out <= '0;
        end else if (start) begin
            shift_out <= tx_word;
        end else if (!cs_n && !sclk_prev && sclk) begin
            shift_out <= {shift_out[`SPI_WORD_BITS-2:0], 1'b0};
        end
    end

    // received word stays until the next valid frame
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_word <= '0;
        end else if (done) begin
            rx_word <= shift_in;
        end
    end
endmodule
`default_nettype wire

/* File: core/switch_fault_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfs_consts.svh"
module switch_fault_supervisor #(
    parameter int CHANNELS = 4,
    parameter int WD_STEP = `WD_STEP_CYCLES,
    parameter int OC_STEP = `OC_STEP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // mode pins and strap
    input wire logic wake,
    input wire logic device_reset_n,
    input wire sfs_pkg::strap_t fail_safe_strap_resistor,
    input wire logic [CHANNELS-1:0] direct_drive_inputs,
    // serial link
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so_out,
    output logic spi_so_oe_n,
    // analog sense comparators
    input wire logic vdd_ok,
    input wire logic overvoltage,
    input wire logic undervoltage,
    input wire logic [CHANNELS-1:0] overtemp_hot,
    input wire logic [CHANNELS-1:0] open_load,
    input wire logic [CHANNELS-1:0] oc_low_hit,
    input wire logic [CHANNELS-1:0] oc_high_hit,
    // threshold selection to the comparators
    output logic [2:0] overcurrent_low_level_field,
    output logic overcurrent_high_level_field,
    // switch drive and status
    output logic [CHANNELS-1:0] switch_out,
    output logic fault_flag_n,
    output logic watchdog_expired_status,
    output sfs_pkg::mode_t mode
);
    import sfs_pkg::*;

    // ****************************************
    // pin synchronisation
    // ****************************************
    localparam int NSYNC = 5 * CHANNELS + 10;
    logic [NSYNC-1:0] sync_level;
    logic wake_s, rstn_s, sclk_s, cs_s, cs_sel, si_s, vdd_s, ov_s, uv_s;
    logic [1:0] strap_s;
    logic [CHANNELS-1:0] hot_s, ol_s, ocl_s, och_s, din_s;

    pin_sync #(.WIDTH(NSYNC)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin({wake, device_reset_n, spi_sclk, ~spi_cs_n, spi_si, vdd_ok, overvoltage, undervoltage,
              fail_safe_strap_resistor, overtemp_hot, open_load, oc_low_hit, oc_high_hit, direct_drive_inputs}),
        .level(sync_level)
    );
    assign {wake_s, rstn_s, sclk_s, cs_sel, si_s, vdd_s, ov_s, uv_s,
            strap_s, hot_s, ol_s, ocl_s, och_s, din_s} = sync_level;
    // select travels inverted, so the synchroniser resets to the idle level
    assign cs_s = !cs_sel;

    logic grounded;
    assign grounded = (strap_t'(strap_s) == STRAP_GROUND);

    // ****************************************
    // serial link
    // ****************************************
    logic [`SPI_WORD_BITS-1:0] tx_word, rx_word, shown;
    logic frame_start, frame_done;

    spi_word_slave u_spi (
        .sys_clk(sys_clk),
        .rst(rst),
        .sclk(sclk_s),
        .cs_n(cs_s),
        .si(si_s),
        .so_out(spi_so_out),
        .so_oe_n(spi_so_oe_n),
        .tx_word(tx_word),
        .rx_word(rx_word),
        .start(frame_start),
        .done(frame_done)
    );

    // the slave's rx_word lags done by a cycle; decode the word one cycle later
    logic word_valid;
    logic [`SPI_WORD_BITS-1:0] rx_hold;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word_valid <= 1'b0;
        end else begin
            word_valid <= frame_done;
        end
    end
    assign rx_hold = rx_word;

    // ****************************************
    // configuration registers
    // ****************************************
    logic [CHANNELS-1:0] spi_on;
    logic [3:0] oc_cfg;
    logic [2:0] oc_time;
    logic [CHANNELS-1:0] unlatch;
    logic overvoltage_shutdown_disable;
    logic [1:0] wd_period;
    logic fs_enter;
    logic [2:0] waddr;
    assign waddr = rx_hold[`SPI_ADDR_HI:`SPI_ADDR_LO];

    // sleep and supply loss wipe settings; fail-safe entry resets only some
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            spi_on <= '0;
            oc_cfg <= `CFG_RESET;
            oc_time <= '0;
            unlatch <= '0;
            overvoltage_shutdown_disable <= 1'b0;
            wd_period <= '0;
        end else if (!vdd_s || mode == MODE_SLEEP) begin
            spi_on <= '0;
            oc_cfg <= `CFG_RESET;
            oc_time <= '0;
            unlatch <= '0;
            overvoltage_shutdown_disable <= 1'b0;
            wd_period <= '0;
        end else if (fs_enter) begin
            oc_cfg <= `CFG_RESET;
            oc_time <= '0;
            unlatch <= '0;
        end else if (word_valid) begin
            unique case (waddr)
                `SPI_ADDR_CMD: spi_on <= rx_hold[CHANNELS-1:0];
                `SPI_ADDR_OC: begin
                    oc_cfg <= rx_hold[`FLD_OC_HIGH:`FLD_OC_LOW_LO];
                    oc_time <= rx_hold[`FLD_OC_TIME_LO+2:`FLD_OC_TIME_LO];
                end
                `SPI_ADDR_OT: begin
                    unlatch <= rx_hold[CHANNELS-1:0];
                    overvoltage_shutdown_disable <= rx_hold[`FLD_OVERVOLTAGE_SHUTDOWN_DISABLE];
                end
                `SPI_ADDR_WD: wd_period <= rx_hold[`FLD_WD_PERIOD_LO+1:`FLD_WD_PERIOD_LO];
                default: ; // remaining addresses only read status
            endcase
        end
    end

    // one of eight low and one of two high thresholds, always both active
    assign overcurrent_low_level_field = oc_cfg[2:0];
    assign overcurrent_high_level_field = oc_cfg[`FLD_OC_HIGH];

    // ****************************************
    // watchdog
    // ****************************************
    logic wake_prev, rstn_prev, armed, wd_last, wd_toggle, wd_expired;
    logic [31:0] wd_cnt, wd_limit;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_prev <= 1'b0;
            rstn_prev <= 1'b0;
        end else begin
            wake_prev <= wake_s;
            rstn_prev <= rstn_s;
        end
    end

    // arming needs a rising mode pin; grounding or sleep disarms
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (grounded || mode == MODE_SLEEP && !wake_s && !rstn_s) begin
            armed <= 1'b0;
        end else if ((wake_s && !wake_prev) || (rstn_s && !rstn_prev)) begin
            armed <= 1'b1;
        end
    end

    assign wd_toggle = word_valid && (rx_hold[`SPI_BIT_WD] != wd_last);
    assign wd_limit = 32'(WD_STEP) * {30'h0, wd_period} + 32'(WD_STEP);
    assign wd_expired = armed && !grounded && (wd_cnt >= wd_limit - 32'h1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wd_last <= 1'b0;
        end else if (word_valid) begin
            wd_last <= rx_hold[`SPI_BIT_WD];
        end
    end

    // counter keeps running in fail-safe, saturating at the limit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wd_cnt <= '0;
        end else if (!armed || wd_toggle) begin
            wd_cnt <= '0;
        end else if (wd_cnt < wd_limit) begin
            wd_cnt <= wd_cnt + 32'h1;
        end
    end

    // ****************************************
    // operating mode
    // ****************************************
    logic both_fell;
    assign both_fell = wake_prev && rstn_prev && !wake_s && !rstn_s;
    assign fs_enter = (mode == MODE_NORMAL) && wd_expired && vdd_s;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode <= MODE_SLEEP;
        end else begin
            unique case (mode)
                MODE_SLEEP: if (wake_s || rstn_s) mode <= MODE_NORMAL;
                MODE_NORMAL: begin
                    if (!wake_s && !rstn_s) begin
                        mode <= MODE_SLEEP;
                    end else if (fs_enter) begin
                        mode <= MODE_FAILSAFE;
                    end
                end
                MODE_FAILSAFE: begin
                    if (grounded) begin
                        mode <= MODE_NORMAL;
                    end else if (both_fell) begin
                        mode <= MODE_SLEEP;
                    end
                end
                default: mode <= MODE_SLEEP;
            endcase
        end
    end

    assign watchdog_expired_status = (mode == MODE_FAILSAFE);

    // ****************************************
    // channel command and protections
    // ****************************************
    logic [CHANNELS-1:0] fs_pattern, cmd, cmd_prev, cmd_rise, ot_latch, oc_latch, oc_trip, drive;
    logic ov_block;

    // strap picks the fail-safe pattern, commands and pins ignored
    always_comb begin
        fs_pattern = '0;
        unique case (strap_t'(strap_s))
            STRAP_CH0: fs_pattern[0] = 1'b1;
            STRAP_CH0_CH2: fs_pattern = CHANNELS'(4'b0101);
            default: fs_pattern = '0;
        endcase
    end

    assign cmd = (mode == MODE_FAILSAFE) ? fs_pattern :
                 (mode == MODE_SLEEP) ? '0 : (spi_on | din_s);
    assign cmd_rise = cmd & ~cmd_prev;
    assign ov_block = ov_s && !overvoltage_shutdown_disable;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_prev <= '0;
        end else begin
            cmd_prev <= cmd;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            logic [31:0] oc_timer;
            // low-threshold timing while the switch is on and over the threshold
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    oc_timer <= '0;
                end else if (!(switch_out[ch] && ocl_s[ch])) begin
                    oc_timer <= '0;
                end else if (!oc_trip[ch]) begin
                    oc_timer <= oc_timer + 32'h1;
                end
            end
            assign oc_trip[ch] = switch_out[ch] && (och_s[ch] ||
                                 oc_timer >= 32'(OC_STEP) * {29'h0, oc_time} + 32'(OC_STEP) - 32'h1);

            // overcurrent latch: set wins over the off-on release
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    oc_latch[ch] <= 1'b0;
                end else if (oc_trip[ch]) begin
                    oc_latch[ch] <= 1'b1;
                end else if (cmd_rise[ch]) begin
                    oc_latch[ch] <= 1'b0;
                end
            end

            // latched overtemperature needs cool die and a fresh switch-on, or a grounded strap in fail-safe
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    ot_latch[ch] <= 1'b0;
                end else if (hot_s[ch] && !unlatch[ch]) begin
                    ot_latch[ch] <= 1'b1;
                end else if (cmd_rise[ch] || mode == MODE_FAILSAFE && grounded) begin
                    ot_latch[ch] <= 1'b0;
                end
            end

            // unlatched mode restarts as soon as the hot comparator drops
            assign drive[ch] = cmd[ch] && !hot_s[ch] && !ot_latch[ch] && !oc_latch[ch] && !ov_block;
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            switch_out <= '0;
        end else begin
            switch_out <= drive;
        end
    end

    // ****************************************
    // fault flags and response word
    // ****************************************
    logic [CHANNELS-1:0] ot_flag, oc_flag;
    logic ov_flag;

    // flags survive supply loss; clear only bits that were shown, set wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ot_flag <= '0;
            oc_flag <= '0;
            ov_flag <= 1'b0;
        end else begin
            ot_flag <= (ot_flag & ~(frame_done ? shown[`OD_OT_LO+CHANNELS-1:`OD_OT_LO] : '0)) | hot_s;
            oc_flag <= (oc_flag & ~(frame_done ? shown[`OD_OC_LO+CHANNELS-1:`OD_OC_LO] : '0))
                       | oc_trip | (hot_s & ~unlatch);
            ov_flag <= (ov_flag && !(frame_done && shown[`OD_OVF])) || ov_block;
        end
    end

    always_comb begin
        tx_word = '0;
        tx_word[`OD_OV_WARN] = ov_s;
        tx_word[`OD_OT_LO+CHANNELS-1:`OD_OT_LO] = ot_flag;
        tx_word[`OD_OC_LO+CHANNELS-1:`OD_OC_LO] = oc_flag;
        tx_word[`OD_WD_EXPIRED] = watchdog_expired_status;
        tx_word[`OD_OVF] = ov_flag;
    end

    // snapshot of what this frame shifts out, so later events are kept
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shown <= '0;
        end else if (frame_start) begin
            shown <= tx_word;
        end
    end

    // latched faults keep the flag low until released by a switch-on, or for overtemperature by a grounded strap in fail-safe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_flag_n <= 1'b1;
        end else begin
            fault_flag_n <= !(|hot_s || ov_s || uv_s || |ol_s || |oc_latch || |ot_latch);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ground_blocks_fs: assert property (grounded |=> mode != MODE_FAILSAFE)
        else $error("fail-safe entered with grounded strap");
    a_expiry_enters_fs: assert property (fs_enter && (wake_s || rstn_s) |=> mode == MODE_FAILSAFE)
        else $error("watchdog expiry did not enter fail-safe");
    a_fs_pattern_out: assert property (mode == MODE_FAILSAFE ##1 mode == MODE_FAILSAFE
        |-> (switch_out & ~$past(fs_pattern)) == '0)
        else $error("fail-safe output outside strap pattern");
    a_fs_defaults_set: assert property (fs_enter |=> oc_cfg == `CFG_RESET && oc_time == 3'h0 && unlatch == '0)
        else $error("fail-safe entry kept overcurrent settings");
    a_sleep_off: assert property (mode == MODE_SLEEP |=> switch_out == '0)
        else $error("output on in sleep");
    a_high_trip: assert property (switch_out[0] && och_s[0] |=> oc_latch[0] ##1 !switch_out[0])
        else $error("high overcurrent did not latch off");
    a_ov_off: assert property (ov_block |=> switch_out == '0 && ov_flag)
        else $error("overvoltage did not hold outputs off");
    a_flag_low: assert property (|hot_s || ov_s || |oc_latch |=> !fault_flag_n)
        else $error("fault flag not pulled low");
    a_read_clears_ot: assert property (frame_done && shown[`OD_OT_LO] && !hot_s[0] |=> !ot_flag[0])
        else $error("overtemperature flag not cleared by read");
    a_vdd_loss_clear: assert property (!vdd_s |=> spi_on == '0 && overvoltage_shutdown_disable == 1'b0)
        else $error("settings kept without logic supply");
    a_wd_restart: assert property (armed && wd_toggle |=> wd_cnt == 32'h0)
        else $error("watchdog counter not restarted");

    c_fs_entry: cover property (mode == MODE_NORMAL ##1 mode == MODE_FAILSAFE);
    c_oc_latch: cover property (oc_trip[0] ##1 oc_latch[0]);
    c_read_done: cover property (frame_done && |shown);
    c_fs_exit: cover property (mode == MODE_FAILSAFE ##1 mode == MODE_SLEEP);
endmodule
`default_nettype wire

/* File: include/sfs_consts.svh */
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// ****************************************
// serial word layout
// ****************************************
`define SPI_WORD_BITS 16
`define SPI_BIT_WD 15
`define SPI_ADDR_HI 14
`define SPI_ADDR_LO 12
`define SPI_ADDR_CMD 3'h0
`define SPI_ADDR_OC 3'h1
`define SPI_ADDR_OT 3'h2
`define SPI_ADDR_WD 3'h3

// ****************************************
// write fields, reset value of every field is zero
// ****************************************
`define FLD_OC_LOW_LO 0
`define FLD_OC_HIGH 3
`define FLD_OC_TIME_LO 4
`define FLD_OVERVOLTAGE_SHUTDOWN_DISABLE 4
`define FLD_WD_PERIOD_LO 0
`define CFG_RESET 4'h0

// ****************************************
// response word bit positions
// ****************************************
`define OD_OV_WARN 13
`define OD_OT_LO 8
`define OD_OC_LO 4
`define OD_WD_EXPIRED 2
`define OD_OVF 1

// ****************************************
// timing
// ****************************************
`define SYS_CLK_KHZ 25000
`define WD_STEP_MS 10
`define OC_STEP_US 500
`define WD_STEP_CYCLES (`WD_STEP_MS * `SYS_CLK_KHZ)
`define OC_STEP_CYCLES ((`OC_STEP_US * `SYS_CLK_KHZ) / 1000)

`endif

/* File: include/sfs_pkg.sv */
package sfs_pkg;
    // operating mode, gray along sleep -> normal -> fail-safe
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_FAILSAFE = 2'b11
    } mode_t;

    // strap resistor code as seen by the strap comparator
    typedef enum logic [1:0] {
        STRAP_GROUND = 2'b00,
        STRAP_ALL_OFF = 2'b01,
        STRAP_CH0 = 2'b10,
        STRAP_CH0_CH2 = 2'b11
    } strap_t;
endpackage
